// [lsst_controller.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lsst_params.svh"
module lsst_controller
    import lsst_pkg::*;
#(
    parameter int PIXELS = `LSST_PIXELS,
    parameter int CNT_W  = `LSST_CNT_W,
    parameter int DIV    = `LSST_CLK_DIV
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RESET,
    lsst_link_if.controller        LINK,
    input  wire logic              I_ENABLE,
    input  wire logic [CNT_W-1:0]  I_HIGH_CLKS,
    input  wire logic [CNT_W-1:0]  I_PERIOD_CLKS,
    output logic [11:0]            O_PIXEL,
    output logic                   O_PIXEL_VALID,
    output logic                   O_LINE_DONE
);
    ////////////////////////////////////////////////////////////////
    lsst_ctl_state_t  state_q;
    logic [7:0]       div_q;
    logic             sclk_q;
    logic             start_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] high_lim;
    logic [CNT_W-1:0] low_lim;
    logic [CNT_W-1:0] strobe_cnt_q;
    logic [CNT_W-1:0] taken_q;
    logic             strobe_d1_q;
    wire  logic       sclk_rise = (div_q == 8'(DIV - 1));
    // [RULE_03] Clamp pulse widths
    always_comb begin
        high_lim = (I_HIGH_CLKS < CNT_W'(`LSST_START_HIGH_MIN)) ? CNT_W'(`LSST_START_HIGH_MIN) : I_HIGH_CLKS;
        // [RULE_06] Split sets integration
        low_lim  = (I_PERIOD_CLKS > high_lim + CNT_W'(`LSST_START_LOW_MIN)) ?
                   I_PERIOD_CLKS - high_lim : CNT_W'(`LSST_START_LOW_MIN);
    end
    ////////////////////////////////////////////////////////////////
    // [RULE_09] Even duty divider
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            div_q  <= '0;
            sclk_q <= 1'b0;
        end else begin
            div_q <= sclk_rise ? 8'h00 : div_q + 8'h01;
            if (sclk_rise) begin
                sclk_q <= 1'b1;
            end else if (div_q == 8'(DIV / 2 - 1)) begin
                sclk_q <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // [RULE_11] Period counting
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_q <= LSST_IDLE;
            cnt_q   <= '0;
            start_q <= 1'b0;
        end else if (sclk_rise) begin
            case (state_q)
                LSST_IDLE: begin
                    if (I_ENABLE) begin
                        state_q <= LSST_HIGH;
                        start_q <= 1'b1;
                        cnt_q   <= CNT_W'(1);
                    end
                end
                LSST_HIGH: begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    if (cnt_q >= high_lim) begin
                        state_q <= LSST_LOW;
                        start_q <= 1'b0;
                        cnt_q   <= CNT_W'(1);
                    end
                end
                LSST_LOW: begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    // [RULE_12] No extra period
                    if (cnt_q >= low_lim) begin
                        state_q <= I_ENABLE ? LSST_HIGH : LSST_IDLE;
                        start_q <= I_ENABLE;
                        cnt_q   <= CNT_W'(1);
                    end
                end
                default: state_q <= LSST_IDLE;
            endcase
        end
    end
    assign LINK.sensor_clk       = sclk_q;
    assign LINK.scan_start_pulse = start_q;
    ////////////////////////////////////////////////////////////////
    // [RULE_07] Sample on strobe
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            strobe_d1_q   <= 1'b0;
            strobe_cnt_q  <= '0;
            taken_q       <= '0;
            O_PIXEL       <= '0;
            O_PIXEL_VALID <= 1'b0;
            O_LINE_DONE   <= 1'b0;
        end else begin
            strobe_d1_q   <= LINK.pixel_strobe;
            O_PIXEL_VALID <= 1'b0;
            O_LINE_DONE   <= 1'b0;
            if (start_q) begin
                strobe_cnt_q <= '0;
                taken_q      <= '0;
            end else if (LINK.pixel_strobe && !strobe_d1_q) begin
                strobe_cnt_q <= strobe_cnt_q + CNT_W'(1);
                // [RULE_08] From 50th strobe
                if (strobe_cnt_q >= CNT_W'(`LSST_FIRST_STROBE - 1) && taken_q < CNT_W'(PIXELS)) begin
                    // [RULE_13] One per strobe
                    O_PIXEL       <= LINK.video;
                    O_PIXEL_VALID <= 1'b1;
                    taken_q       <= taken_q + CNT_W'(1);
                    O_LINE_DONE   <= (taken_q == CNT_W'(PIXELS - 1));
                end
            end
        end
    end
endmodule : lsst_controller
`default_nettype wire

// [lsst_params.svh]
// Summary of operation
// [RULE_01] Only start pulse and clock drive sensor
// [RULE_02] One pixel per clock, 10 MHz max
// [RULE_03] Start high >=6, low >=64, period >=70
// [RULE_04] Shift begins first edge after start falls
// [RULE_05] Integration equals high time plus 34
// [RULE_06] Controller splits period to set integration
// [RULE_07] Controller samples video on strobe rising edge
// [RULE_08] First valid pixel at 50th strobe
// [RULE_09] Clock duty between 45 and 55 percent
// [RULE_10] Each scan reads 2496 pixels
// [RULE_11] Fastest scan uses 2548-clock period, 64 low; code resets capture when start rises, so low must outlast the shift
// [RULE_12] Avoid overlong period or high time
// [RULE_13] Capture one sample per strobe, full line
// [RULE_14] End flag pulses after last pixel
`ifndef LSST_PARAMS_SVH
`define LSST_PARAMS_SVH
`define LSST_PIXELS        2496
`define LSST_FIRST_STROBE  50
`define LSST_INTEG_EXTRA   34
`define LSST_START_HIGH_MIN 6
`define LSST_START_LOW_MIN 64
`define LSST_PERIOD_MIN    70
`define LSST_PERIOD_FAST   2548
`define LSST_CLK_DIV       10
`define LSST_CNT_W         16
`endif

// [lsst_pkg.sv]
package lsst_pkg;
    typedef enum logic [1:0] {
        LSST_IDLE  = 2'b00,
        LSST_HIGH  = 2'b01,
        LSST_LOW   = 2'b10
    } lsst_ctl_state_t;
    typedef enum logic [0:0] {
        LSST_DEV_WAIT  = 1'b0,
        LSST_DEV_SHIFT = 1'b1
    } lsst_dev_state_t;
endpackage : lsst_pkg

// [lsst_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lsst_link_if;
    logic       scan_start_pulse;
    logic       sensor_clk;
    logic       pixel_strobe;
    logic [11:0] video;
    logic       scan_end_flag;
    modport sensor     (input scan_start_pulse, input sensor_clk,
                        output pixel_strobe, output video, output scan_end_flag);
    modport controller (output scan_start_pulse, output sensor_clk,
                        input pixel_strobe, input video, input scan_end_flag);
endinterface : lsst_link_if
`default_nettype wire

// [lsst_sensor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lsst_params.svh"
module lsst_sensor
    import lsst_pkg::*;
#(
    parameter int PIXELS   = `LSST_PIXELS,
    parameter int CNT_W    = `LSST_CNT_W
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RESET,
    lsst_link_if.sensor            LINK,
    input  wire logic [11:0]       I_PIXEL_VALUE,
    output logic [CNT_W-1:0]       O_PIXEL_INDEX,
    output logic [CNT_W-1:0]       O_INTEG_CYCLES,
    output logic                   O_BUSY
);
    ////////////////////////////////////////////////////////////////
    lsst_dev_state_t  state_q;
    logic             clk_q;
    logic             start_q;
    logic [CNT_W-1:0] pix_q;
    logic [CNT_W-1:0] high_q;
    logic             strobe_q;
    logic [11:0]      video_q;
    logic             end_q;
    wire  logic       clk_rise = LINK.sensor_clk & ~clk_q;
    ////////////////////////////////////////////////////////////////
    // [RULE_01] Sample pins only
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            clk_q   <= 1'b0;
            start_q <= 1'b0;
        end else begin
            clk_q <= LINK.sensor_clk;
            if (clk_rise) begin
                start_q <= LINK.scan_start_pulse;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // [RULE_05] Integration time measure
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            high_q         <= '0;
            O_INTEG_CYCLES <= '0;
        end else if (clk_rise) begin
            if (LINK.scan_start_pulse && !start_q) begin
                high_q <= CNT_W'(1);
            end else if (LINK.scan_start_pulse) begin
                high_q <= high_q + CNT_W'(1);
            end else if (start_q) begin
                O_INTEG_CYCLES <= high_q + CNT_W'(`LSST_INTEG_EXTRA);
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_q  <= LSST_DEV_WAIT;
            pix_q    <= '0;
            strobe_q <= 1'b0;
            video_q  <= '0;
            end_q    <= 1'b0;
        end else begin
            strobe_q <= 1'b0;
            end_q    <= 1'b0;
            if (clk_rise) begin
                case (state_q)
                    LSST_DEV_WAIT: begin
                        // [RULE_04] Start on fall
                        if (start_q && !LINK.scan_start_pulse) begin
                            state_q  <= LSST_DEV_SHIFT;
                            pix_q    <= '0;
                            strobe_q <= 1'b1;
                        end
                    end
                    LSST_DEV_SHIFT: begin
                        // [RULE_02] Pixel per clock
                        strobe_q <= 1'b1;
                        if (pix_q + CNT_W'(1) >= CNT_W'(`LSST_FIRST_STROBE - 1)) begin
                            video_q <= I_PIXEL_VALUE;
                        end
                        pix_q <= pix_q + CNT_W'(1);
                        // [RULE_10] Line length end
                        if (pix_q == CNT_W'(PIXELS + `LSST_FIRST_STROBE - 2)) begin
                            state_q  <= LSST_DEV_WAIT;
                            strobe_q <= 1'b0;
                            // [RULE_14] End pulse
                            end_q    <= 1'b1;
                        end
                    end
                    default: state_q <= LSST_DEV_WAIT;
                endcase
            end
        end
    end
    assign LINK.pixel_strobe  = strobe_q;
    assign LINK.video         = video_q;
    assign LINK.scan_end_flag = end_q;
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PIXEL_INDEX <= '0;
            O_BUSY        <= 1'b0;
        end else begin
            O_PIXEL_INDEX <= pix_q;
            O_BUSY        <= (state_q == LSST_DEV_SHIFT);
        end
    end
endmodule : lsst_sensor
`default_nettype wire

// [lsst_link_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module lsst_link_chk #(
    parameter int PIXELS = 2496,
    parameter int DIV    = 10
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic scan_start_pulse,
    input wire logic sensor_clk,
    input wire logic pixel_strobe,
    input wire logic scan_end_flag
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    localparam int HIGH_MIN = 6 * DIV;
    localparam int LOW_MIN  = 64 * DIV;
    localparam int LAST_STB = PIXELS + 49;
    int   run_q;
    int   strobes_q;
    logic fell_q;
    ////////////////////////////////////////////////////////////////
    // Cycles since last start edge
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            run_q <= 0;
            fell_q <= 1'b0;
        end else begin
            run_q <= $changed(scan_start_pulse) ? 1 : run_q + 1;
            fell_q <= fell_q | $fell(scan_start_pulse);
        end
    end
    // Strobes since start fell
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            strobes_q <= 0;
        end else if ($fell(scan_start_pulse)) begin
            strobes_q <= 0;
        end else if (pixel_strobe) begin
            strobes_q <= strobes_q + 1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_strobe_spacing: assert property (pixel_strobe |=> (!pixel_strobe)[*8])
        else $error("strobes closer than one sensor clock");
    a_strobe_clk_high: assert property (pixel_strobe |-> sensor_clk)
        else $error("strobe outside sensor clock high phase");
    a_shift_begins: assert property ($fell(scan_start_pulse) |-> ##[1:13] pixel_strobe)
        else $error("shift did not start at next sensor clock");
    a_end_count: assert property (scan_end_flag |-> strobes_q == LAST_STB)
        else $error("line end at wrong strobe count");
    a_end_quiet: assert property (scan_end_flag |=> (!scan_end_flag && !pixel_strobe)[*8])
        else $error("end flag not a single pulse after line");
    a_start_high_min: assert property ($fell(scan_start_pulse) |-> run_q >= HIGH_MIN)
        else $error("start high too short");
    a_start_low_min: assert property ($rose(scan_start_pulse) && fell_q |-> run_q >= LOW_MIN)
        else $error("start low too short");
    a_clk_duty_half: assert property ($rose(sensor_clk) |-> sensor_clk[*5] ##1 !sensor_clk)
        else $error("sensor clock duty wrong");
    c_scan_start: cover property ($fell(scan_start_pulse));
    c_first_pixel: cover property (pixel_strobe && strobes_q == 49);
    c_scan_end: cover property (scan_end_flag);
endmodule : lsst_link_chk
`default_nettype wire

// [linear_sensor_scan_timing_test.sv]
`timescale 1ns/100ps
`default_nettype none
module linear_sensor_scan_timing_test;
    localparam int PIXELS = 2496;
    logic        clk;
    logic        rst;
    logic        enable;
    logic        done;
    logic        valid;
    logic        busy;
    logic [15:0] high_clks;
    logic [15:0] period_clks;
    logic [15:0] integ;
    logic [15:0] pix_idx;
    logic [11:0] pix_in;
    logic [11:0] pix_out;
    logic [31:0] seed;
    int          miscompares;
    int          check_count;
    int          pc;
    int          done_cnt;
    logic [11:0] sent[$];
    lsst_link_if link();
    lsst_sensor #(.PIXELS(PIXELS)) i_lsst_sensor (.I_CLK(clk), .I_RESET(rst), .LINK(link),
        .I_PIXEL_VALUE(pix_in), .O_PIXEL_INDEX(pix_idx), .O_INTEG_CYCLES(integ), .O_BUSY(busy));
    lsst_controller #(.PIXELS(PIXELS)) i_lsst_controller (.I_CLK(clk), .I_RESET(rst), .LINK(link),
        .I_ENABLE(enable), .I_HIGH_CLKS(high_clks), .I_PERIOD_CLKS(period_clks),
        .O_PIXEL(pix_out), .O_PIXEL_VALID(valid), .O_LINE_DONE(done));
    lsst_link_chk #(.PIXELS(PIXELS), .DIV(10)) i_lsst_link_chk (.I_CLK(clk), .I_RESET(rst),
        .scan_start_pulse(link.scan_start_pulse), .sensor_clk(link.sensor_clk),
        .pixel_strobe(link.pixel_strobe), .scan_end_flag(link.scan_end_flag));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////
    // Model: new pixel per strobe, compare captures
    always @(negedge clk) begin
        if (link.pixel_strobe === 1'b1) begin
            sent.push_back(pix_in);
            pix_in = 12'(xs() >> 20);
        end
        if (valid === 1'b1) begin
            chk(pix_out === sent[49 + pc], "pixel value");
            chk(done === (pc == PIXELS - 1), "line done timing");
            chk(pix_idx === 16'(49 + pc), "pixel index");
            chk(busy === 1'b1, "busy during line");
            pc++;
        end
        if (done === 1'b1) begin
            done_cnt++;
        end
    end
    // One scan; cut > 0 resets mid-scan
    task automatic run_scan(input int hi, input int cut);
        int n;
        int eff;
        eff = (hi < 6) ? 6 : hi;
        sent.delete();
        pc = 0;
        done_cnt = 0;
        n = 0;
        high_clks = 16'(hi);
        period_clks = 16'(eff + 2620);
        enable = 1'b1;
        while (done_cnt == 0 && n < 40000 && (cut == 0 || n != cut)) begin
            @(negedge clk);
            n++;
        end
        if (cut > 0) begin
            rst = 1'b1;
            @(negedge clk);
            chk(link.pixel_strobe === 1'b0 && valid === 1'b0 && busy === 1'b0, "reset outputs");
            rst = 1'b0;
        end else begin
            chk(pc == PIXELS, "pixel count");
            chk(integ === 16'(eff + 34), "integration");
        end
        enable = 1'b0;
        repeat (800) @(negedge clk);
        $display("scan with high %0d done", hi);
    endtask : run_scan
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        enable = 1'b0;
        high_clks = 16'h0000;
        period_clks = 16'h0000;
        pix_in = 12'h000;
        seed = 32'h0000_0001;
        miscompares = 0;
        check_count = 0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        run_scan(3, 0);
        run_scan(int'(xs() % 32) + 6, 0);
        run_scan(20, 5000);
        run_scan(6, 0);
        stop_test();
    end
endmodule : linear_sensor_scan_timing_test
`default_nettype wire
